/* hw/midb_pkg.sv */
package midb_pkg;
   localparam int DATA_W     = 8;
   localparam int PC_W       = 11;
   localparam int PTR_HI_W   = 3;
   localparam int PC_HI_LSB  = 8;
   localparam int OP_W       = 3;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic       GIE_RESET = 1'b0;
   localparam logic [10:0] PC_RESET = 11'h000;
   localparam logic       DEST_ACC  = 1'b0;
   localparam logic       DEST_REG  = 1'b1;

   typedef enum logic [OP_W-1:0] {
      midb_op_none,
      midb_op_dec,
      midb_op_inc,
      midb_op_inc_skip,
      midb_op_irq_off,
      midb_op_irq_on,
      midb_op_branch
   } midb_op_type;

   typedef enum {
      midb_st_exec,
      midb_st_second
   } midb_state_type;
endpackage : midb_pkg

/* hw/midb_core.sv */
`timescale 1ns/100ps
module midb_core #(
   parameter int DATA_W = 8,
   parameter int PC_W   = 11
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  op_valid,
   input  wire logic [2:0]            op_code,
   input  wire logic                  dest_bit,
   input  wire logic [DATA_W-1:0]     reg_value,
   input  wire logic [DATA_W-1:0]     table_high_pointer,
   input  wire logic [PC_W-1:0]       pc_next_seq,
   output logic                       op_ready,
   output logic                       reg_we,
   output logic [DATA_W-1:0]          reg_wdata,
   output logic [DATA_W-1:0]          accumulator,
   output logic                       zero_flag,
   output logic                       global_irq_enable_bit,
   output logic                       pc_load,
   output logic [PC_W-1:0]            pc_value,
   output logic                       fetch_discard
);
   midb_pkg::midb_state_type state_q;
   midb_pkg::midb_state_type state_d;
   logic [DATA_W-1:0] acc_q;
   logic              zero_q;
   logic              gie_q;
   logic [PC_W-1:0]   pc_q;
   logic              pc_load_q;
   logic              discard_q;
   logic              reg_we_q;
   logic [DATA_W-1:0] reg_wdata_q;

   wire midb_pkg::midb_op_type op = midb_pkg::midb_op_type'(op_code);
   wire               in_exec  = (state_q == midb_pkg::midb_st_exec);
   wire               take     = op_valid && in_exec;
   // Adder shared by both increment forms
   wire [DATA_W-1:0]  inc_val  = reg_value + DATA_W'(1);
   wire [DATA_W-1:0]  dec_val  = reg_value - DATA_W'(1);
   wire               is_dec   = take && (op == midb_pkg::midb_op_dec);
   wire               is_inc   = take && (op == midb_pkg::midb_op_inc);
   wire               is_incsz = take && (op == midb_pkg::midb_op_inc_skip);
   wire               is_arith = is_dec || is_inc || is_incsz;
   wire [DATA_W-1:0]  result   = is_dec ? dec_val : inc_val;
   wire               res_zero = (result == '0);
   wire               skip     = is_incsz && res_zero;
   wire               branch   = take && (op == midb_pkg::midb_op_branch);
   wire [PC_W-1:0]    branch_pc = {table_high_pointer[midb_pkg::PTR_HI_W-1:0], acc_q};

   // Second cycle holds off the next op for branch and taken skip
   assign op_ready = in_exec;

   always_comb begin
      state_d = state_q;
      case (state_q)
         midb_pkg::midb_st_exec: begin
            if (branch || skip) begin
               state_d = midb_pkg::midb_st_second;
            end
         end
         midb_pkg::midb_st_second: begin
            state_d = midb_pkg::midb_st_exec;
         end
         default: begin
            state_d = midb_pkg::midb_st_exec;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= midb_pkg::midb_st_exec;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         acc_q       <= midb_pkg::ACC_RESET;
         zero_q      <= 1'b0;
         reg_we_q    <= 1'b0;
         reg_wdata_q <= '0;
      end else begin
         reg_we_q <= is_arith && (dest_bit == midb_pkg::DEST_REG);
         if (is_arith) begin
            zero_q      <= res_zero;
            reg_wdata_q <= result;
            if (dest_bit == midb_pkg::DEST_ACC) begin
               acc_q <= result;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         gie_q <= midb_pkg::GIE_RESET;
      end else if (take && op == midb_pkg::midb_op_irq_off) begin
         gie_q <= 1'b0;
      end else if (take && op == midb_pkg::midb_op_irq_on) begin
         gie_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pc_q      <= midb_pkg::PC_RESET;
         pc_load_q <= 1'b0;
         discard_q <= 1'b0;
      end else begin
         pc_load_q <= branch;
         discard_q <= branch || skip;
         if (branch) begin
            pc_q <= branch_pc;
         end else if (take) begin
            pc_q <= pc_next_seq;
         end
      end
   end

   assign reg_we                = reg_we_q;
   assign reg_wdata             = reg_wdata_q;
   assign accumulator           = acc_q;
   assign zero_flag             = zero_q;
   assign global_irq_enable_bit = gie_q;
   assign pc_load               = pc_load_q;
   assign pc_value              = pc_q;
   assign fetch_discard         = discard_q;
endmodule : midb_core

/* test/midb_checker.sv */
`timescale 1ns/100ps
module midb_checker (
   input wire logic       ref_clk, rst, op_valid, dest_bit, op_ready, reg_we, zero_flag,
   input wire logic       global_irq_enable_bit, pc_load, fetch_discard,
   input wire logic [2:0] op_code,
   input wire logic [7:0] reg_value, table_high_pointer, reg_wdata, accumulator,
   input wire logic [10:0] pc_value
);
   wire       tk = op_valid && op_ready;
   wire [2:0] tl = table_high_pointer[2:0];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   dec_reg_a: assert property (tk && op_code == 3'h1 && dest_bit |=>
      reg_we && reg_wdata == $past(reg_value) - 8'h01) else $error("dec result wrong");
   inc_acc_a: assert property (tk && op_code == 3'h2 && !dest_bit |=>
      accumulator == $past(reg_value) + 8'h01 && zero_flag == (accumulator == 8'h00)) else $error("inc wrong");
   irq_off_a: assert property (tk && op_code == 3'h4 |=> !global_irq_enable_bit) else $error("irq off");
   irq_on_a: assert property (tk && op_code == 3'h5 |=> global_irq_enable_bit) else $error("irq on");
   branch_hi_a: assert property (tk && op_code == 3'h6 |=>
      pc_load && pc_value[10:8] == $past(tl)) else $error("branch high bits");
   branch_lo_a: assert property (tk && op_code == 3'h6 |=>
      pc_value[7:0] == $past(accumulator) && !op_ready ##1 op_ready) else $error("branch low bits");
   skip_taken_a: assert property (tk && op_code == 3'h3 && reg_value == 8'hFF |=>
      fetch_discard && !op_ready ##1 op_ready) else $error("skip wrong");
   one_cycle_a: assert property (tk && op_code inside {3'h1, 3'h2, 3'h4, 3'h5} |=>
      op_ready && !fetch_discard && !pc_load) else $error("stall seen");
endmodule : midb_checker
bind midb_core midb_checker chk_i (.*);

/* test/mcu_incdec_branch_intctl_ops_tb_top.sv */
`timescale 1ns/100ps
module mcu_incdec_branch_intctl_ops_tb_top;
   logic        ref_clk = 0, rst = 1, op_valid = 0, dest_bit = 0;
   logic [2:0]  op_code = 3'h0;
   logic [7:0]  reg_value = 8'h00, table_high_pointer = 8'h00, reg_wdata, accumulator;
   logic        op_ready, reg_we, zero_flag, global_irq_enable_bit, pc_load, fetch_discard;
   logic [10:0] pc_value;
   // Distinct sequential address so a missed advance shows up
   logic [10:0] pc_seq = 11'h2A5;
   int          n_errors = 0, tests_run = 0, cyc = 0;
   // Row: op, dest, register value, expected result
   logic [19:0] rows [7] = '{20'h2_0100, 20'h3_00FF, 20'h4_7F80, 20'h5_FF00, 20'hA_0001, 20'h8_0000, 20'h6_1011};
   midb_core uut (.ref_clk, .rst, .op_valid, .op_code, .dest_bit, .reg_value, .table_high_pointer,
      .pc_next_seq(pc_seq), .op_ready, .reg_we, .reg_wdata, .accumulator, .zero_flag,
      .global_irq_enable_bit, .pc_load, .pc_value, .fetch_discard);
   always #25 ref_clk = ~ref_clk;
   task chk(string n, logic [10:0] e, logic [10:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task end_sim;
      $display("%0d checks, %0d errors", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   // Leaves op_valid up so a caller can test refusal
   task go(logic [2:0] o, logic d, logic [7:0] v);
      @(posedge ref_clk);
      #1 op_valid = 1;
      {op_code, dest_bit, reg_value} = {o, d, v};
      @(posedge ref_clk);
      #1;
   endtask : go
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 500) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      #1 rst = 0;
      chk("reset", 11'h400, {op_ready, global_irq_enable_bit, accumulator, zero_flag});
      foreach (rows[i]) begin
         go(rows[i][19:17], rows[i][16], rows[i][15:8]);
         op_valid = 0;
         chk("result", rows[i][7:0], rows[i][19] ? global_irq_enable_bit : rows[i][16] ? reg_wdata : accumulator);
         if (!rows[i][19]) chk("zero", rows[i][7:0] == 8'h00, zero_flag);
         chk("reg_we", rows[i][16], reg_we);
         chk("seq_pc", pc_seq, pc_value);
         $display("row %0d done", i);
      end
      go(3'h3, 1, 8'hFF);
      {op_code, dest_bit, reg_value} = {3'h1, 1'b0, 8'h05};
      chk("skip", 11'h500, {fetch_discard, op_ready, reg_we, reg_wdata});
      @(posedge ref_clk);
      #1 op_valid = 0;
      chk("refused", 11'h011, accumulator);
      $display("skip done");
      table_high_pointer = 8'hFD;
      go(3'h6, 0, 8'h00);
      op_valid = 0;
      chk("branch", 11'h511, pc_value);
      chk("pcload", 11'h002, {pc_load, op_ready});
      $display("branch done");
      end_sim();
   end
endmodule : mcu_incdec_branch_intctl_ops_tb_top
